/* rtl/gpp_pkg.sv */
// Package of the parallel port pin block: register map, field positions, carriers.
// Assumes a 32-bit APB master and byte addresses within one 256-byte window.
package gpp_pkg;

   // ****************************************************************
   // Sizes
   // ****************************************************************
   localparam int GPP_PORT_W = 8;
   localparam int GPP_BIDIR_N = 4;
   localparam int GPP_SYNC_N = 6;
   localparam int GPP_SYNC_P2 = 4;
   localparam int GPP_SYNC_P6 = 5;

   // ****************************************************************
   // Register offsets
   // ****************************************************************
   localparam logic [7:0] GPP_BIDIR_STRIDE = 8'h10;
   localparam logic [7:0] GPP_OFS_DATA = 8'h00;
   localparam logic [7:0] GPP_OFS_DIR = 8'h04;
   localparam logic [7:0] GPP_OFS_PULL = 8'h08;
   localparam logic [7:0] GPP_P2_DATA = 8'h40;
   localparam logic [7:0] GPP_P2_PULL = 8'h44;
   localparam logic [7:0] GPP_P6_DATA = 8'h50;
   localparam logic [7:0] GPP_P6_DIR = 8'h54;
   localparam logic [7:0] GPP_P6_PULL = 8'h58;
   localparam logic [7:0] GPP_RTO_CTL = 8'h60;
   localparam logic [7:0] GPP_RTO_BUF = 8'h64;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int GPP_RTO_LO_EN = 0;
   localparam int GPP_RTO_HI_EN = 1;
   localparam int GPP_RTO_WIDE = 2;
   localparam int GPP_NMI_BIT = 0;
   localparam int GPP_SCK_BIT = 5;
   localparam int GPP_P2_PULL_LSB = 2;
   localparam int GPP_P6_HI_LSB = 6;
   localparam logic [7:0] GPP_P2_PULL_MASK = 8'hFC;
   localparam logic [7:0] GPP_P6_OUT_MASK = 8'h0F;
   localparam logic [7:0] GPP_P6_BIDIR_MASK = 8'hC0;

   // ****************************************************************
   // Carriers
   // ****************************************************************
   typedef struct packed {
      logic [GPP_PORT_W-1:0] o;
      logic [GPP_PORT_W-1:0] oe;
      logic [GPP_PORT_W-1:0] pu;
   } gpp_pad_type;

   typedef struct packed {
      logic [GPP_BIDIR_N-1:0][GPP_PORT_W-1:0] lat;
      logic [GPP_BIDIR_N-1:0][GPP_PORT_W-1:0] dir;
      logic [GPP_BIDIR_N-1:0][GPP_PORT_W-1:0] pu_en;
      logic p2_pu;
      logic [GPP_PORT_W-1:0] p6_lat;
      logic [GPP_PORT_W-1:0] p6_dir;
      logic [GPP_PORT_W-1:0] p6_pu;
      logic [2:0] rto_ctl;
      logic [GPP_PORT_W-1:0] rto_buf;
      logic [GPP_SYNC_N-1:0][GPP_PORT_W-1:0] s1;
      logic [GPP_SYNC_N-1:0][GPP_PORT_W-1:0] s2;
      logic [GPP_SYNC_N-1:0][GPP_PORT_W-1:0] s3;
      logic [GPP_SYNC_N-1:0][GPP_PORT_W-1:0] flt;
      logic [31:0] rdata;
      logic ready;
      logic err;
      gpp_pad_type [GPP_BIDIR_N-1:0] bpad;
      gpp_pad_type p2pad;
      gpp_pad_type p6pad;
      logic nmi;
   } gpp_state_type;

endpackage

/* rtl/gpp_port_pins.sv */
// Pin logic of the general-purpose parallel ports, reached over APB.
// Assumes pins arrive asynchronously, timer triggers and serial controls on clk_sys.
// Function
// - Every bit of ports zero, one, three, seven selects input or output.
// - Pull-up applies only when enabled by software and the pin is input.
// - Port zero real-time output loads as two nibbles or one byte.
// - Port two bit zero feeds the non-maskable interrupt; level stays readable.
// - One control enables pull-ups of port two bits two to seven together.
// - Port two bit five drives serial clock one when serial mode selects it.
// - Port six bits zero to three are outputs only, shared with address extension.
// - Port six bits six and seven choose direction, pull-up when input.
module gpp_port_pins
   import gpp_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Bidirectional ports: index 0 zero, 1 one, 2 three, 3 seven
   input wire logic [GPP_BIDIR_N-1:0][GPP_PORT_W-1:0] bidir_pin_in,
   output gpp_pad_type [GPP_BIDIR_N-1:0] bidir_pad,
   // Port two
   input wire logic [GPP_PORT_W-1:0] port_two_in,
   output gpp_pad_type port_two_pad,
   output logic nmi_level,
   // Port six
   input wire logic [GPP_PORT_W-1:0] port_six_in,
   output gpp_pad_type port_six_pad,
   // Alternate functions on clk_sys
   input wire logic serial_mode_ctl_ch_one,
   input wire logic serial_clock_ch_one,
   input wire logic addr_ext_sel,
   input wire logic [3:0] upper_address_ext,
   input wire logic rto_trig_lo,
   input wire logic rto_trig_hi
);

   // ****************************************************************
   // Helpers
   // ****************************************************************

   // Input bits show the pin, output bits show the latch
   function automatic logic [GPP_PORT_W-1:0] rd_mix(input logic [GPP_PORT_W-1:0] dir,
      input logic [GPP_PORT_W-1:0] lat, input logic [GPP_PORT_W-1:0] pin);
      rd_mix = (dir & lat) | (~dir & pin);
   endfunction

   // Zero-extend a port byte to a bus word
   function automatic logic [31:0] word(input logic [GPP_PORT_W-1:0] b);
      word = {{(32-GPP_PORT_W){1'b0}}, b};
   endfunction

   gpp_state_type st_q;
   gpp_state_type st_d;
   logic [7:0] a;
   logic [7:0] wb;
   logic setup;
   logic access;
   logic hit;
   logic [31:0] rd;
   logic sck_drive;
   logic [GPP_PORT_W-1:0] pin_raw [GPP_SYNC_N];

   assign a = paddr[7:0];
   assign wb = pwdata[GPP_PORT_W-1:0];
   assign setup = psel && !penable;
   assign access = psel && penable && st_q.ready;
   assign sck_drive = serial_mode_ctl_ch_one;

   // Raw pins gathered for one synchroniser loop
   always_comb
   begin
      for (int k = 0; k < GPP_BIDIR_N; k++)
      begin
         pin_raw[k] = bidir_pin_in[k];
      end
      pin_raw[GPP_SYNC_P2] = port_two_in;
      pin_raw[GPP_SYNC_P6] = port_six_in;
   end

   // ****************************************************************
   // Read decode
   // ****************************************************************

   // Address decode and read data; upper address bits must be zero
   always_comb
   begin
      hit = 1'b0;
      rd = '0;
      for (int k = 0; k < GPP_BIDIR_N; k++)
      begin
         if (a == 8'(k * GPP_BIDIR_STRIDE) + GPP_OFS_DATA)
         begin
            hit = 1'b1;
            rd = word(rd_mix(st_q.dir[k], st_q.lat[k], st_q.flt[k]));
         end
         if (a == 8'(k * GPP_BIDIR_STRIDE) + GPP_OFS_DIR)
         begin
            hit = 1'b1;
            rd = word(st_q.dir[k]);
         end
         if (a == 8'(k * GPP_BIDIR_STRIDE) + GPP_OFS_PULL)
         begin
            hit = 1'b1;
            rd = word(st_q.pu_en[k]);
         end
      end
      unique case (a)
         GPP_P2_DATA:
         begin
            hit = 1'b1;
            rd = word(st_q.flt[GPP_SYNC_P2]);
         end
         GPP_P2_PULL:
         begin
            hit = 1'b1;
            rd = {31'h0, st_q.p2_pu};
         end
         GPP_P6_DATA:
         begin
            hit = 1'b1;
            rd = word((st_q.p6_lat & GPP_P6_OUT_MASK)
               | (rd_mix(st_q.p6_dir, st_q.p6_lat, st_q.flt[GPP_SYNC_P6]) & GPP_P6_BIDIR_MASK));
         end
         GPP_P6_DIR:
         begin
            hit = 1'b1;
            rd = word(st_q.p6_dir);
         end
         GPP_P6_PULL:
         begin
            hit = 1'b1;
            rd = word(st_q.p6_pu);
         end
         GPP_RTO_CTL:
         begin
            hit = 1'b1;
            rd = {29'h0, st_q.rto_ctl};
         end
         GPP_RTO_BUF:
         begin
            hit = 1'b1;
            rd = word(st_q.rto_buf);
         end
         default:
         begin
         end
      endcase
      if (paddr[31:8] != 24'h0)
      begin
         hit = 1'b0;
         rd = '0;
      end
   end

   // ****************************************************************
   // Next state
   // ****************************************************************

   // Bus answer, register writes, real-time loads, synchronisers, pads
   always_comb
   begin
      st_d = st_q;
      // Zero-wait answer: ready rises in the access cycle, drops after
      st_d.ready = setup;
      st_d.err = setup && !hit;
      st_d.rdata = (setup && !pwrite) ? rd : '0;
      if (access && pwrite && !st_q.err)
      begin
         for (int k = 0; k < GPP_BIDIR_N; k++)
         begin
            if (a == 8'(k * GPP_BIDIR_STRIDE) + GPP_OFS_DATA)
               st_d.lat[k] = wb;
            if (a == 8'(k * GPP_BIDIR_STRIDE) + GPP_OFS_DIR)
               st_d.dir[k] = wb;
            if (a == 8'(k * GPP_BIDIR_STRIDE) + GPP_OFS_PULL)
               st_d.pu_en[k] = wb;
         end
         unique case (a)
            GPP_P2_PULL: st_d.p2_pu = wb[0];
            GPP_P6_DATA: st_d.p6_lat = wb & (GPP_P6_OUT_MASK | GPP_P6_BIDIR_MASK);
            GPP_P6_DIR: st_d.p6_dir = wb & GPP_P6_BIDIR_MASK;
            GPP_P6_PULL: st_d.p6_pu = wb & GPP_P6_BIDIR_MASK;
            GPP_RTO_CTL: st_d.rto_ctl = wb[2:0];
            GPP_RTO_BUF: st_d.rto_buf = wb;
            default:
            begin
            end
         endcase
      end
      // nibble or byte load
      // Trigger wins over a software write of the same cycle
      if (st_q.rto_ctl[GPP_RTO_WIDE])
      begin
         if (rto_trig_lo)
            st_d.lat[0] = st_q.rto_buf;
      end
      else
      begin
         if (rto_trig_lo && st_q.rto_ctl[GPP_RTO_LO_EN])
            st_d.lat[0][3:0] = st_q.rto_buf[3:0];
         if (rto_trig_hi && st_q.rto_ctl[GPP_RTO_HI_EN])
            st_d.lat[0][7:4] = st_q.rto_buf[7:4];
      end
      // Three stages; a change counts only when stages two and three agree
      for (int k = 0; k < GPP_SYNC_N; k++)
      begin
         st_d.s1[k] = pin_raw[k];
         st_d.s2[k] = st_q.s1[k];
         st_d.s3[k] = st_q.s2[k];
         for (int b = 0; b < GPP_PORT_W; b++)
         begin
            if (st_q.s2[k][b] == st_q.s3[k][b])
               st_d.flt[k][b] = st_q.s3[k][b];
         end
      end
      for (int k = 0; k < GPP_BIDIR_N; k++)
      begin
         st_d.bpad[k].o = st_q.lat[k];
         st_d.bpad[k].oe = st_q.dir[k];
         st_d.bpad[k].pu = st_q.pu_en[k] & ~st_q.dir[k];
      end
      st_d.p2pad.o = '0;
      st_d.p2pad.oe = '0;
      // group pull-up on bits two up
      st_d.p2pad.pu = st_q.p2_pu ? GPP_P2_PULL_MASK : '0;
      if (sck_drive)
      begin
         st_d.p2pad.o[GPP_SCK_BIT] = serial_clock_ch_one;
         st_d.p2pad.oe[GPP_SCK_BIT] = 1'b1;
         st_d.p2pad.pu[GPP_SCK_BIT] = 1'b0;
      end
      st_d.nmi = st_q.flt[GPP_SYNC_P2][GPP_NMI_BIT];
      st_d.p6pad.o = st_q.p6_lat;
      if (addr_ext_sel)
         st_d.p6pad.o[3:0] = upper_address_ext;
      st_d.p6pad.oe = GPP_P6_OUT_MASK | st_q.p6_dir;
      st_d.p6pad.pu = st_q.p6_pu & ~st_q.p6_dir;
   end

   // State register; unused port six bits four and five stay zero
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         st_q <= '0;
      else
         st_q <= st_d;
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************

   // Every output taken straight from the state register
   assign prdata = st_q.rdata;
   assign pready = st_q.ready;
   assign pslverr = st_q.err;
   assign bidir_pad = st_q.bpad;
   assign port_two_pad = st_q.p2pad;
   assign port_six_pad = st_q.p6pad;
   assign nmi_level = st_q.nmi;

endmodule

/* dv/gpp_port_pins_sva.sv */
// Checker of the parallel port pin block, bound to its top module.
// Assumes one clock domain with an active low asynchronous reset.
module gpp_port_pins_chk
   import gpp_pkg::*;
(
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_n,
   // APB answer
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   // Pads and alternates
   input wire gpp_pad_type [GPP_BIDIR_N-1:0] bidir_pad,
   input wire logic [GPP_PORT_W-1:0] port_two_in,
   input wire gpp_pad_type port_two_pad,
   input wire logic nmi_level,
   input wire gpp_pad_type port_six_pad,
   input wire logic serial_mode_ctl_ch_one,
   input wire logic serial_clock_ch_one,
   input wire logic addr_ext_sel,
   input wire logic [3:0] upper_address_ext
);
   timeunit 1ns;
   timeprecision 1ns;
   // ********************
   // Startup count
   // ********************
   logic [1:0] up_q;
   logic [1:0] up_d;
   // Pads lag reset release by one edge; the count skips the first three edges
   always_comb up_d = (up_q == 2'h3) ? up_q : up_q + 2'h1;
   always_ff @(posedge clk_sys or negedge rst_n)
      if (!rst_n) up_q <= 2'h0;
      else up_q <= up_d;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // ********************
   // Properties
   // ********************
   apb_answer_a: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   err_ready_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   pull_input_a: assert property ((bidir_pad[0].pu & bidir_pad[0].oe | bidir_pad[1].pu & bidir_pad[1].oe
      | bidir_pad[2].pu & bidir_pad[2].oe | bidir_pad[3].pu & bidir_pad[3].oe) == 8'h00)
      else $error("pull-up on driven pin");
   p2_nodrive_a: assert property ((port_two_pad.oe & 8'hDF) == 8'h00)
      else $error("port two driven");
   p2_group_a: assert property (port_two_pad.pu[1:0] == 2'h0
      && {port_two_pad.pu[7:6], port_two_pad.pu[4:2]} inside {5'h00, 5'h1F}) else $error("port two pull split");
   sck_drive_a: assert property (up_q == 2'h3 |=> port_two_pad.oe[5] == $past(serial_mode_ctl_ch_one)
      && (!port_two_pad.oe[5] || port_two_pad.o[5] == $past(serial_clock_ch_one))) else $error("serial clock pad");
   nmi_follow_a: assert property ($stable(port_two_in[0]) [*8] |-> nmi_level == port_two_in[0])
      else $error("nmi level stale");
   p6_out_a: assert property (up_q == 2'h3 |-> port_six_pad.oe[5:0] == 6'h0F)
      else $error("port six low nibble not output");
   addr_ext_a: assert property (up_q == 2'h3 && addr_ext_sel |=> port_six_pad.o[3:0] == $past(upper_address_ext))
      else $error("address extension missing");
   p6_pull_a: assert property ((port_six_pad.pu & (port_six_pad.oe | 8'h3F)) == 8'h00)
      else $error("port six pull-up wrong");
   cover property (pslverr);
   cover property (serial_mode_ctl_ch_one ##1 port_two_pad.oe[5]);
   cover property ($rose(nmi_level));
endmodule

bind gpp_port_pins gpp_port_pins_chk u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
   .pready(pready), .pslverr(pslverr), .bidir_pad(bidir_pad), .port_two_in(port_two_in),
   .port_two_pad(port_two_pad), .nmi_level(nmi_level), .port_six_pad(port_six_pad),
   .serial_mode_ctl_ch_one(serial_mode_ctl_ch_one), .serial_clock_ch_one(serial_clock_ch_one),
   .addr_ext_sel(addr_ext_sel), .upper_address_ext(upper_address_ext));

/* dv/gpp_port_pins_tb.sv */
// Self-checking bench of the parallel port pin block over APB.
// Assumes the checker is bound separately; pins are driven directly.
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin err_count++; \
   $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module gpp_port_pins_tb
   import gpp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   // Row: direction, pull enable, latch, pin level, then expected read and expected pad pull-up
   typedef struct packed {logic [7:0] dir; logic [7:0] pull; logic [7:0] lat; logic [7:0] pin;
      logic [7:0] rd_exp; logic [7:0] pu_exp;} gpp_row_type;
   gpp_row_type rows [4] = '{'{8'hF0, 8'hFF, 8'hA5, 8'h3C, 8'hAC, 8'h0F},
      '{8'h0F, 8'h33, 8'h5A, 8'hC3, 8'hCA, 8'h30},
      '{8'hFF, 8'hFF, 8'h81, 8'h00, 8'h81, 8'h00},
      '{8'h00, 8'hAA, 8'h7E, 8'hFF, 8'hFF, 8'hAA}};
   logic clk_sys = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, er;
   logic [31:0] paddr = '0, pwdata = '0, prdata, rd;
   logic pready, pslverr, nmi_level, smode = 0, sclk = 0, xsel = 0, tlo = 0, thi = 0;
   logic [3:0] xaddr = '0;
   logic [GPP_BIDIR_N-1:0][GPP_PORT_W-1:0] bidir_pin_in = '0;
   logic [7:0] p2_in = '0, p6_in = '0;
   gpp_pad_type [GPP_BIDIR_N-1:0] bidir_pad;
   gpp_pad_type port_two_pad, port_six_pad;
   int err_count = 0, checks_done = 0;
   gpp_port_pins uut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .bidir_pin_in(bidir_pin_in), .bidir_pad(bidir_pad), .port_two_in(p2_in), .port_two_pad(port_two_pad),
      .nmi_level(nmi_level), .port_six_in(p6_in), .port_six_pad(port_six_pad), .serial_mode_ctl_ch_one(smode),
      .serial_clock_ch_one(sclk), .addr_ext_sel(xsel), .upper_address_ext(xaddr), .rto_trig_lo(tlo),
      .rto_trig_hi(thi));
   // 25 MHz system clock
   always #20 clk_sys = ~clk_sys;
   // ********************
   // Tasks
   // ********************
   task automatic test_done();
      $display("checks %0d errors %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // One APB transfer; the wait for ready is bounded
   task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do
      begin
         @(posedge clk_sys);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      if (pready !== 1'b1)
      begin
         err_count++;
         test_done();
      end
   endtask
   // Let registered pads land; looks at an edge, so later stimulus stays on the edge
   task automatic settle();
      repeat (2) @(posedge clk_sys);
   endtask
   // One-cycle timer trigger
   task automatic trig(input logic hi, input logic [2:0] ctl, input logic [7:0] buf_v);
      apb(1'b1, GPP_RTO_BUF, buf_v);
      apb(1'b1, GPP_RTO_CTL, ctl);
      @(posedge clk_sys);
      thi <= hi; tlo <= !hi;
      @(posedge clk_sys);
      thi <= 1'b0; tlo <= 1'b0;
      settle();
   endtask
   // ********************
   // Sequence
   // ********************
   initial
   begin
      repeat (20) @(posedge clk_sys);
      `CHK(port_six_pad.oe, 8'h00)
      rst_n <= 1'b1;
      // Ordinary cases: each bidirectional port in turn
      for (int k = 0; k < 4; k++)
      begin
         bidir_pin_in[k] <= rows[k].pin;
         apb(1'b1, 8'(k) * GPP_BIDIR_STRIDE + GPP_OFS_DATA, rows[k].lat);
         apb(1'b1, 8'(k) * GPP_BIDIR_STRIDE + GPP_OFS_DIR, rows[k].dir);
         apb(1'b1, 8'(k) * GPP_BIDIR_STRIDE + GPP_OFS_PULL, rows[k].pull);
         apb(1'b0, 8'(k) * GPP_BIDIR_STRIDE + GPP_OFS_DATA, 32'h0);
         `CHK(rd, {24'h0, rows[k].rd_exp})
         settle();
         `CHK(bidir_pad[k].oe, rows[k].dir)
         `CHK(bidir_pad[k].pu, rows[k].pu_exp)
         `CHK(bidir_pad[k].o, rows[k].lat)
      end
      // Port two: group pull, ignored write, interrupt pin level
      p2_in <= 8'h5B;
      apb(1'b1, GPP_P2_PULL, 32'h1);
      apb(1'b1, GPP_P2_DATA, 32'hFF);
      apb(1'b0, GPP_P2_DATA, 32'h0);
      `CHK(rd, 32'h5B)
      settle();
      `CHK(port_two_pad.pu, 8'hFC)
      `CHK(port_two_pad.oe, 8'h00)
      `CHK(nmi_level, 1'b1)
      smode <= 1'b1; sclk <= 1'b1;
      settle();
      `CHK({port_two_pad.oe, port_two_pad.o[5], port_two_pad.pu}, 17'h041DC)
      // Port six: address extension over the latch, upper pair by direction
      smode <= 1'b0; p6_in <= 8'hFF; xsel <= 1'b1; xaddr <= 4'h9;
      apb(1'b1, GPP_P6_DATA, 32'h45);
      apb(1'b1, GPP_P6_DIR, 32'h40);
      apb(1'b1, GPP_P6_PULL, 32'hFF);
      apb(1'b0, GPP_P6_DATA, 32'h0);
      `CHK(rd, 32'hC5)
      settle();
      `CHK({port_six_pad.oe, port_six_pad.pu, port_six_pad.o[3:0]}, 20'h4F809)
      xsel <= 1'b0;
      settle();
      `CHK(port_six_pad.o[3:0], 4'h5)
      // Real-time output: low nibble, high nibble, whole byte
      trig(1'b0, 3'h1, 8'hC3);
      `CHK(bidir_pad[0].o, 8'hA3)
      trig(1'b1, 3'h2, 8'hC3);
      `CHK(bidir_pad[0].o, 8'hC3)
      trig(1'b0, 3'h4, 8'h5E);
      `CHK(bidir_pad[0].o, 8'h5E)
      // Unmapped places answer with an error and no data
      apb(1'b0, 32'hFC, 32'h0);
      `CHK({er, rd}, 33'h100000000)
      apb(1'b1, 32'h100, 32'h1);
      `CHK(er, 1'b1)
      // Refused write must leave the port zero latch alone
      settle();
      `CHK(bidir_pad[0].o, 8'h5E)
      // Second reset clears the drivers
      rst_n <= 1'b0;
      settle();
      `CHK(bidir_pad[2].oe, 8'h00)
      test_done();
   end
endmodule
